// ---- core/sld_cfg.svh ----
// Constants for the serial LCD segment driver: sizes, counts and timing.
// Assumes a 100 MHz system clock; included by every design file that needs it.
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH

// ****************************************************************
// Display geometry
// ****************************************************************
`define SLD_SEG_COUNT      40
`define SLD_COM_COUNT      4
`define SLD_LATCH_BITS     160
`define SLD_BITS_DUTY_3    120
`define SLD_CMD_BITS       8
`define SLD_BIT_CNT_W      8

// ****************************************************************
// Frame timing
// ****************************************************************
`define SLD_FRAME_DIV      24
`define SLD_STEPS_DUTY_3   8
`define SLD_STEPS_DUTY_4   6
`define SLD_CLK_PERIOD_NS  10
`define SLD_RC_PERIOD_NS   100000
`define SLD_RC_HALF_CYCLES (`SLD_RC_PERIOD_NS / `SLD_CLK_PERIOD_NS / 2)

`endif

// ---- core/sld_driver.sv ----
// Serial LCD segment driver top: serial shift-in, display latch, clock source and drive.
// Assumes all pins other than RST_N are asynchronous to CLK and are synchronised here.
//
// Overview of operation
// - Serial data is captured into the shift register on each shift clock rise.
// - A high bit lights its segment, a low bit turns it off.
// - A load pulse latches display data or takes the bits as a command.
// - Frame rate equals the selected oscillator frequency divided by 24.
// - Source select low uses internal oscillator; high takes external clock, internal off.
// - Duty pin high selects 1/3 duty, low selects 1/4 duty.
// - Holding reset low initialises all internal state.
// - In 1/3 duty only the first three commons are driven.
// - In 1/4 duty all four commons are driven, one per frame quarter.
// - Forty segment outputs address 160 positions at 1/4, 120 at 1/3.
`include "sld_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sld_driver #(
  parameter int SEG_COUNT       = `SLD_SEG_COUNT,
  parameter int RC_HALF_CYCLES  = `SLD_RC_HALF_CYCLES
) (
  // Clock and reset.
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  // Serial link from the host.
  input  wire logic                 SER_DATA,
  input  wire logic                 SHIFT_CLK,
  input  wire logic                 LOAD,
  // Mode straps.
  input  wire logic                 CLOCK_SOURCE_SELECT,
  input  wire logic                 DUTY_SELECT,
  input  wire logic                 TEST,
  // Oscillator pin.
  input  wire logic                 RC_OSC_PIN_IN,
  output logic                      RC_OSC_PIN_OUT,
  output logic                      RC_OSC_PIN_OE,
  // Display drive.
  output logic [3:0]                COMMON_OUT,
  output logic [SEG_COUNT-1:0]      SEGMENT_OUTPUTS,
  output logic                      FRAME_POL,
  output logic [`SLD_CMD_BITS-1:0]  COMMAND
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************

  // The latch layout is fixed to forty columns and needs a non-zero oscillator.
  if (SEG_COUNT != `SLD_SEG_COUNT || RC_HALF_CYCLES < 1) begin : g_bad_param
    $error("sld_driver: unsupported parameter values");
  end

  localparam int LATCH_BITS = SEG_COUNT * `SLD_COM_COUNT;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic       sclk_prev;
  logic       load_prev;
  logic       osc_prev;

  // Two flops per pin; the first stage feeds only the second.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {TEST, RC_OSC_PIN_IN, DUTY_SELECT, CLOCK_SOURCE_SELECT, LOAD, SHIFT_CLK};
      sync_b <= sync_a;
    end
  end

  wire sclk_s    = sync_b[0];
  wire load_s    = sync_b[1];
  wire ext_sel   = sync_b[2];
  wire duty_s    = sync_b[3];
  wire osc_pin_s = sync_b[4];
  wire test_s    = sync_b[5]; // Held low by the system; not used by the logic.

  // Edge history of the synchronised pins.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sclk_prev <= 1'b0;
      load_prev <= 1'b0;
      osc_prev  <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
      load_prev <= load_s;
      osc_prev  <= osc_pin_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_prev;
  wire load_rise = load_s & ~load_prev;

  logic [1:0] data_sync;

  // Serial data passes two flops before the shift register reads it.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      data_sync <= 2'h0;
    end else begin
      data_sync <= {data_sync[0], SER_DATA};
    end
  end

  wire ser_data_s = data_sync[1];

  // ****************************************************************
  // Serial shift register and display latch
  // ****************************************************************

  logic [LATCH_BITS-1:0]      shift_reg;
  logic [LATCH_BITS-1:0]      latch;
  logic [`SLD_BIT_CNT_W-1:0]  bit_cnt;

  // A load after exactly a command's worth of bits is a command write.
  wire is_command = (bit_cnt == `SLD_BIT_CNT_W'(`SLD_CMD_BITS));
  wire cnt_full   = (bit_cnt == {`SLD_BIT_CNT_W{1'b1}});

  // Shift on each shift clock rise; count bits since the last load.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      shift_reg <= '0;
      bit_cnt   <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[LATCH_BITS-2:0], ser_data_s};
      if (!cnt_full) begin
        bit_cnt <= bit_cnt + `SLD_BIT_CNT_W'(1);
      end
    end else if (load_rise) begin
      bit_cnt <= '0;
    end
  end

  // Latch and command update only on a load pulse.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      latch   <= '0;
      COMMAND <= '0;
    end else if (load_rise) begin
      if (is_command) begin
        COMMAND <= shift_reg[`SLD_CMD_BITS-1:0];
      end else begin
        latch <= shift_reg;
      end
    end
  end

  // ****************************************************************
  // Oscillator source
  // ****************************************************************

  logic [$clog2(RC_HALF_CYCLES+1)-1:0] rc_cnt;
  logic                                rc_level;

  wire rc_wrap = (rc_cnt == ($bits(rc_cnt))'(RC_HALF_CYCLES - 1));

  // Internal RC model runs only while the internal source is selected.
  always_ff @(posedge CLK) begin
    if (!RST_N || ext_sel) begin
      rc_cnt   <= '0;
      rc_level <= 1'b0;
    end else if (rc_wrap) begin
      rc_cnt   <= '0;
      rc_level <= ~rc_level;
    end else begin
      rc_cnt <= rc_cnt + ($bits(rc_cnt))'(1);
    end
  end

  // External clock rises are ticks when selected, else internal rises.
  wire ext_tick = ext_sel & osc_pin_s & ~osc_prev;
  wire int_tick = ~ext_sel & rc_wrap & ~rc_level;
  wire osc_tick = ext_tick | int_tick;

  // Pin is driven only by the internal oscillator.
  assign RC_OSC_PIN_OUT = rc_level;
  assign RC_OSC_PIN_OE  = ~ext_sel;

  // ****************************************************************
  // Frame sequencing and drive
  // ****************************************************************

  sld_pkg::sld_duty_e duty;
  logic [1:0]         phase;
  logic               pol;

  // High on the duty pin selects third duty.
  assign duty = duty_s ? sld_pkg::SLD_DUTY_THIRD : sld_pkg::SLD_DUTY_QUARTER;

  sld_frame_gen u_frame (
    .clk       (CLK),
    .rst_n     (RST_N),
    .osc_tick  (osc_tick),
    .duty      (duty),
    .phase     (phase),
    .frame_pol (pol)
  );

  // Row r of the latch holds columns for common r.
  logic [SEG_COUNT-1:0] row [`SLD_COM_COUNT];
  for (genvar r = 0; r < `SLD_COM_COUNT; r++) begin : g_row
    assign row[r] = latch[r*SEG_COUNT +: SEG_COUNT];
  end

  wire             third   = (duty == sld_pkg::SLD_DUTY_THIRD);
  wire       [3:0] com_hot = 4'h1 << phase;
  wire       [3:0] com_sel = third ? (com_hot & 4'h7) : com_hot;

  // Registered drive of commons and the selected row of segments.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      COMMON_OUT      <= 4'h0;
      SEGMENT_OUTPUTS <= '0;
      FRAME_POL       <= 1'b0;
    end else begin
      COMMON_OUT      <= com_sel;
      SEGMENT_OUTPUTS <= row[phase]; // High bit lights the segment.
      FRAME_POL       <= pol;
    end
  end

endmodule
`default_nettype wire

// ---- core/sld_frame_gen.sv ----
// Frame sequencer: turns oscillator ticks into common phases and frame polarity.
// Assumes osc_tick is a one-cycle pulse on clk, one per oscillator period.
`include "sld_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sld_frame_gen (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Timing inputs.
  input  wire logic              osc_tick,
  input  wire sld_pkg::sld_duty_e duty,
  // Sequence outputs.
  output logic [1:0]             phase,
  output logic                   frame_pol
);

  // ****************************************************************
  // Step and phase counting
  // ****************************************************************

  logic [3:0] step;

  // A frame is 24 ticks split evenly over the active commons.
  wire        third      = (duty == sld_pkg::SLD_DUTY_THIRD);
  wire  [3:0] step_last  = third ? 4'(`SLD_STEPS_DUTY_3 - 1) : 4'(`SLD_STEPS_DUTY_4 - 1);
  wire  [1:0] phase_last = third ? 2'h2 : 2'h3;
  wire        step_end   = (step >= step_last);
  wire        phase_end  = (phase >= phase_last);

  // Advance on each tick; a duty change mid-frame is clamped by the compares.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step      <= 4'h0;
      phase     <= 2'h0;
      frame_pol <= 1'b0;
    end else if (osc_tick) begin
      if (step_end) begin
        step <= 4'h0;
        if (phase_end) begin
          phase     <= 2'h0;
          frame_pol <= ~frame_pol; // Frame rate is oscillator over 24.
        end else begin
          phase <= phase + 2'h1;
        end
      end else begin
        step <= step + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- core/sld_pkg.sv ----
// Types shared by the serial LCD segment driver files.
// Assumes sld_cfg.svh is on the include path.
`include "sld_cfg.svh"

package sld_pkg;

  // Multiplex duty selected by the duty pin.
  typedef enum logic {SLD_DUTY_QUARTER, SLD_DUTY_THIRD} sld_duty_e;

  // Index of the active common row.
  typedef logic [1:0] sld_phase_t;

endpackage

// ---- tb/sld_driver_properties.sv ----
// Checker for the serial LCD segment driver top, watching its ports only.
// Assumes mode straps change only while RST_N is low.
`timescale 1ns/1ps
`default_nettype none
module sld_driver_properties #(
  parameter int SEG_COUNT      = 40,
  parameter int RC_HALF_CYCLES = 2
) (
  input wire logic                 CLK,
  input wire logic                 RST_N,
  input wire logic                 LOAD,
  input wire logic                 CLOCK_SOURCE_SELECT,
  input wire logic                 DUTY_SELECT,
  input wire logic                 RC_OSC_PIN_OUT,
  input wire logic                 RC_OSC_PIN_OE,
  input wire logic [3:0]           COMMON_OUT,
  input wire logic [SEG_COUNT-1:0] SEGMENT_OUTPUTS,
  input wire logic                 FRAME_POL,
  input wire logic [7:0]           COMMAND
);
  localparam int QD = 12 * RC_HALF_CYCLES - 1;
  localparam int TD = 16 * RC_HALF_CYCLES - 1;
  localparam int FR = 48 * RC_HALF_CYCLES;
  logic [3:0] up;
  logic [3:0] quiet;
  wire logic  steady = (up > 4'h4);
  // Counts clocks since reset release and since LOAD was last high.
  always_ff @(posedge CLK) begin
    up    <= !RST_N ? 4'h0 : (up == 4'hF ? up : up + 4'h1);
    quiet <= (!RST_N || LOAD) ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // One common period at each duty, ending in the move to the next common.
  sequence s_quarter;
    ##QD (COMMON_OUT == 4'h1) ##1 (COMMON_OUT == 4'h2);
  endsequence
  sequence s_third;
    ##TD (COMMON_OUT == 4'h1) ##1 (COMMON_OUT == 4'h2);
  endsequence
  a_reset_clears: assert property (disable iff (1'b0) !RST_N |=>
    (SEGMENT_OUTPUTS == '0) && (COMMON_OUT == 4'h0) && (COMMAND == 8'h00) && !FRAME_POL) else $error("reset state");
  a_common_onehot: assert property (up == 4'hF |-> $onehot(COMMON_OUT)) else $error("common not one-hot");
  a_third_no_fourth: assert property (steady && DUTY_SELECT |-> !COMMON_OUT[3]) else $error("fourth common");
  a_latch_holds: assert property (quiet > 4'h8 && $stable(COMMON_OUT) && COMMON_OUT == $past(COMMON_OUT, 2)
    |-> $stable(SEGMENT_OUTPUTS)) else $error("segments moved without load");
  a_osc_pin_oe: assert property (steady |-> RC_OSC_PIN_OE == !CLOCK_SOURCE_SELECT) else $error("osc enable");
  a_rc_stopped: assert property (steady && CLOCK_SOURCE_SELECT |=> $stable(RC_OSC_PIN_OUT)) else $error("rc runs");
  a_quarter_dwell: assert property (steady && !CLOCK_SOURCE_SELECT && !DUTY_SELECT && $rose(COMMON_OUT[0])
    |-> s_quarter) else $error("quarter dwell");
  a_third_dwell: assert property (steady && !CLOCK_SOURCE_SELECT && DUTY_SELECT && $rose(COMMON_OUT[0])
    |-> s_third) else $error("third dwell");
  a_frame_div: assert property ($changed(FRAME_POL) && !CLOCK_SOURCE_SELECT |-> ##FR $changed(FRAME_POL))
    else $error("frame length");
endmodule
bind sld_driver sld_driver_properties #(.SEG_COUNT(SEG_COUNT), .RC_HALF_CYCLES(RC_HALF_CYCLES)) chk (
  .CLK(CLK), .RST_N(RST_N), .LOAD(LOAD), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .DUTY_SELECT(DUTY_SELECT),
  .RC_OSC_PIN_OUT(RC_OSC_PIN_OUT), .RC_OSC_PIN_OE(RC_OSC_PIN_OE), .COMMON_OUT(COMMON_OUT),
  .SEGMENT_OUTPUTS(SEGMENT_OUTPUTS), .FRAME_POL(FRAME_POL), .COMMAND(COMMAND));
`default_nettype wire

// ---- tb/sld_driver_tb.sv ----
// Self-checking bench for the segment driver, with a reference model of shift register and latch.
// Assumes the driver and host model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sld_driver_tb;
  localparam int RC = 2;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         sel = 1'b0;
  logic         duty = 1'b0;
  logic         osc_in = 1'b0;
  logic [2:0]   odiv = 3'h0;
  logic         ser, shc, ld, osc_out, osc_oe, frame_pol;
  logic [3:0]   com;
  logic [39:0]  seg;
  logic [7:0]   cmd, cmd_m;
  logic [31:0]  lfsr = 32'h0B196F5D;
  logic [159:0] sr_m, latch_m;
  int           cnt_m, n_fail = 0, compares = 0;
  always #5 clk = ~clk;
  // External oscillator with a 16-clock period.
  always @(posedge clk) begin
    odiv <= odiv + 3'h1;
    if (odiv == 3'h0) osc_in <= ~osc_in;
  end
  sld_host_model host (.clk(clk), .ser_data(ser), .shift_clk(shc), .load(ld));
  sld_driver #(.RC_HALF_CYCLES(RC)) dut (.CLK(clk), .RST_N(rst_n), .SER_DATA(ser), .SHIFT_CLK(shc), .LOAD(ld),
    .CLOCK_SOURCE_SELECT(sel), .DUTY_SELECT(duty), .TEST(1'b0), .RC_OSC_PIN_IN(osc_in), .RC_OSC_PIN_OUT(osc_out),
    .RC_OSC_PIN_OE(osc_oe), .COMMON_OUT(com), .SEGMENT_OUTPUTS(seg), .FRAME_POL(frame_pol), .COMMAND(cmd));
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Checks one value and reports a mismatch.
  task automatic check(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // Fails and ends the run once a wait count has reached its 2000-clock limit.
  task automatic timeout(input int k);
    if (k >= 2000) begin
      check(1'b0, "wait ran out");
      close_out();
    end
  endtask
  // Resets with new straps and clears the model.
  task automatic restart(input logic s, input logic d);
    rst_n <= 1'b0;
    sel   <= s;
    duty  <= d;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    sr_m = '0;
    latch_m = '0;
    cmd_m = 8'h00;
    cnt_m = 0;
    repeat (8) @(posedge clk);
  endtask
  // Steps the stimulus shift register once.
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Shifts random bits through the host and the model.
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      host.send_bit(lfsr[0]);
      sr_m = {sr_m[158:0], lfsr[0]};
      cnt_m++;
    end
  endtask
  // Eight bits since the last load form a command, any other count loads the display.
  task automatic load();
    host.pulse_load();
    if (cnt_m == 8) cmd_m = sr_m[7:0];
    else latch_m = sr_m;
    cnt_m = 0;
  endtask
  // Waits for common r, then compares its segment row.
  task automatic chk_row(input int r);
    int k;
    k = 0;
    while (com !== 4'(4'h1 << r) && k < 2000) begin
      @(posedge clk);
      k++;
    end
    timeout(k);
    repeat (2) @(posedge clk);
    check(seg === latch_m[r*40 +: 40], "segment row");
  endtask
  // Measures clocks between two frame polarity changes.
  task automatic chk_frame(input int exp);
    int k;
    logic p;
    for (int j = 0; j < 2; j++) begin
      k = 0;
      p = frame_pol;
      while (frame_pol === p && k < 2000) begin
        @(posedge clk);
        k++;
      end
      timeout(k);
    end
    check(k == exp, "frame length");
  endtask
  // Main sequence: quarter duty, third duty, then external clock.
  initial begin
    restart(1'b0, 1'b0);
    check(osc_oe === 1'b1, "osc enable");
    fill(160);
    load();
    for (int r = 0; r < 4; r++) chk_row(r);
    chk_frame(48 * RC);
    fill(8);
    load();
    check(cmd === cmd_m, "command word");
    chk_row(2);
    fill(5);
    chk_row(1);
    load();
    chk_row(0);
    restart(1'b0, 1'b1);
    check(seg === 40'h00_0000_0000, "segments after reset");
    fill(160);
    load();
    for (int r = 0; r < 3; r++) chk_row(r);
    chk_frame(48 * RC);
    restart(1'b1, 1'b0);
    check(osc_oe === 1'b0, "osc enable");
    fill(40);
    load();
    for (int r = 0; r < 4; r++) chk_row(r);
    chk_frame(384);
    close_out();
  end
endmodule
`default_nettype wire

// ---- tb/sld_host_model.sv ----
// Host model driving the three-wire serial link of the segment driver.
// Assumes tasks are called just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module sld_host_model (
  input  wire logic clk,
  output logic      ser_data,
  output logic      shift_clk,
  output logic      load
);
  // Link idles low at time zero.
  initial begin
    ser_data  = 1'b0;
    shift_clk = 1'b0;
    load      = 1'b0;
  end
  // Holds each level for four clocks, above the three-clock minimum.
  task automatic hold();
    repeat (4) @(posedge clk);
  endtask
  // Sends one bit, high meaning segment on; data is inverted once its hold ends.
  task automatic send_bit(input logic b);
    ser_data <= b;
    hold();
    shift_clk <= 1'b1;
    hold();
    shift_clk <= 1'b0;
    ser_data  <= ~b;
    hold();
  endtask
  // Pulses LOAD after the last bit, never near a shift clock rise.
  task automatic pulse_load();
    load <= 1'b1;
    hold();
    load <= 1'b0;
    hold();
  endtask
endmodule
`default_nettype wire
